// ==== rtl/rss_sequencer.sv ====
// Strobe-based power sequencer with its slot configuration registers
`timescale 1ns/1ps
`include "rss_map.svh"

module rss_sequencer
    import rss_pkg::*;
#(
    parameter logic [23:0] DLY_SHORT_CYC = 24'(`RSS_DLY_SHORT_CYC),
    parameter logic [23:0] DLY_LONG_CYC  = 24'(`RSS_DLY_LONG_CYC)
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire rss_reg_req_t reg_req,
    input  wire logic         pw_unlock,
    input  wire logic         pwr_up_req,
    input  wire logic         pwr_dn_req,
    output rss_rail_en_t      rail_en,
    output logic [7:0]        reg_rdata,
    output logic              seq_busy
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Slot code selects this strobe only inside the sequenced range
    function automatic logic slot_hit(input logic [3:0] code, input logic [3:0] strobe);
        slot_hit = (code >= `RSS_SLOT_MIN) && (code <= `RSS_SLOT_MAX)
                   && (code == strobe);
    endfunction : slot_hit

    // Delay that follows strobe k on the way up
    function automatic logic [23:0] gap_after(input logic [3:0] k, input logic sel);
        if (k == `RSS_STROBE_PENULT) begin
            gap_after = sel ? DLY_LONG_CYC : DLY_SHORT_CYC;
        end else begin
            gap_after = DLY_SHORT_CYC;
        end
    endfunction : gap_after

    // Apply one strobe to every output, setting or clearing the matching ones
    function automatic rss_rail_en_t strobe_apply(input rss_rail_en_t en,
                                                  input logic [3:0]   k,
                                                  input logic         on,
                                                  input logic [7:0]   sa,
                                                  input logic [7:0]   sb,
                                                  input logic [7:0]   sl,
                                                  input logic [7:0]   sg);
        rss_rail_en_t r;
        r = en;
        if (slot_hit(sa[7:4], k)) r.buck_two         = on;
        if (slot_hit(sa[3:0], k)) r.buck_one         = on;
        if (slot_hit(sb[7:4], k)) r.buckboost_rail   = on;
        if (slot_hit(sb[3:0], k)) r.buck_three       = on;
        if (slot_hit(sl[3:0], k)) r.linear_regulator = on;
        if (slot_hit(sg[7:4], k)) r.gp_out_two       = on;
        if (slot_hit(sg[3:0], k)) r.gp_out_one       = on;
        strobe_apply = r;
    endfunction : strobe_apply

    // Masked byte write keeps read-only bits at their stored zeros
    function automatic logic [7:0] masked(input logic [7:0] old,
                                          input logic [7:0] wd,
                                          input logic [7:0] m);
        masked = (old & ~m) | (wd & m);
    endfunction : masked

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    rss_state_all_t s_reg;
    rss_state_all_t s_next;
    logic [23:0]    gap;
    logic           wr_ok;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        gap    = '0;
        wr_ok  = reg_req.wr && s_reg.unlocked;

        // Unlock arms one write; any write attempt disarms it, but an unlock in the same cycle wins
        if (reg_req.wr) begin
            s_next.unlocked = 1'b0;
        end
        if (pw_unlock) begin
            s_next.unlocked = 1'b1;
        end

        // Register writes
        if (wr_ok) begin
            unique case (reg_req.addr)
                `RSS_OFS_DELAY_CFG: begin
                    s_next.delay_cfg = masked(s_reg.delay_cfg, reg_req.wdata,
                                              `RSS_MASK_DELAY_CFG);
                end
                `RSS_OFS_RAIL_SLOT_A: begin
                    s_next.rail_slot_a = reg_req.wdata;
                end
                `RSS_OFS_RAIL_SLOT_B: begin
                    s_next.rail_slot_b = reg_req.wdata;
                end
                `RSS_OFS_RSVD_CFG: begin
                    s_next.sequencer_reserved_cfg = masked(s_reg.sequencer_reserved_cfg,
                                                           reg_req.wdata,
                                                           `RSS_MASK_RSVD_CFG);
                end
                `RSS_OFS_LINEAR_SLOT: begin
                    s_next.linear_reg_slot = reg_req.wdata;
                end
                `RSS_OFS_GP_SLOT: begin
                    s_next.gp_output_slot = reg_req.wdata;
                end
                default: begin
                end
            endcase
        end

        // Read data registered one cycle after the request; unmapped reads zero
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `RSS_OFS_DELAY_CFG:   s_next.rdata = s_reg.delay_cfg;
                `RSS_OFS_RAIL_SLOT_A: s_next.rdata = s_reg.rail_slot_a;
                `RSS_OFS_RAIL_SLOT_B: s_next.rdata = s_reg.rail_slot_b;
                `RSS_OFS_RSVD_CFG:    s_next.rdata = s_reg.sequencer_reserved_cfg;
                `RSS_OFS_LINEAR_SLOT: s_next.rdata = s_reg.linear_reg_slot;
                `RSS_OFS_GP_SLOT:     s_next.rdata = s_reg.gp_output_slot;
                default:              s_next.rdata = 8'h00;
            endcase
        end

        // Sequencer; slots are sampled live at each strobe
        unique case (s_reg.state)
            RSS_OFF: begin
                if (pwr_up_req) begin
                    s_next.state  = RSS_UP;
                    s_next.strobe = `RSS_STROBE_FIRST;
                    s_next.cnt    = '0;
                end
            end
            RSS_UP: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - 24'h000001;
                end else begin
                    s_next.en = strobe_apply(s_reg.en, s_reg.strobe, 1'b1,
                                             s_reg.rail_slot_a, s_reg.rail_slot_b,
                                             s_reg.linear_reg_slot,
                                             s_reg.gp_output_slot);
                    if (s_reg.strobe == `RSS_STROBE_LAST) begin
                        s_next.state = RSS_ON;
                    end else begin
                        // Count ends one short so a strobe lands exactly on the gap
                        s_next.cnt    = gap_after(s_reg.strobe,
                                                  s_reg.delay_cfg[`RSS_BIT_LAST_DLY_SEL])
                                        - 24'h000001;
                        s_next.strobe = s_reg.strobe + 4'h1;
                    end
                end
            end
            RSS_ON: begin
                if (pwr_dn_req) begin
                    s_next.state  = RSS_DOWN;
                    s_next.strobe = `RSS_STROBE_LAST;
                    s_next.cnt    = '0;
                end
            end
            RSS_DOWN: begin
                if (s_reg.cnt != '0) begin
                    s_next.cnt = s_reg.cnt - 24'h000001;
                end else begin
                    s_next.en = strobe_apply(s_reg.en, s_reg.strobe, 1'b0,
                                             s_reg.rail_slot_a, s_reg.rail_slot_b,
                                             s_reg.linear_reg_slot,
                                             s_reg.gp_output_slot);
                    if (s_reg.strobe == `RSS_STROBE_FIRST) begin
                        s_next.state = RSS_OFF;
                    end else begin
                        // Gap before strobe k-1 mirrors the gap after it going up
                        gap = gap_after(s_reg.strobe - 4'h1,
                                        s_reg.delay_cfg[`RSS_BIT_LAST_DLY_SEL]);
                        if (s_reg.delay_cfg[`RSS_BIT_PD_FACTOR]) begin
                            gap = 24'(gap * `RSS_PD_FACTOR);
                        end
                        s_next.cnt    = gap - 24'h000001;
                        s_next.strobe = s_reg.strobe - 4'h1;
                    end
                end
            end
            default: begin
                s_next.state = RSS_OFF;
            end
        endcase

        // Busy is registered so the output comes straight from a flop
        s_next.busy = (s_next.state == RSS_UP) || (s_next.state == RSS_DOWN);
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.delay_cfg              <= `RSS_RST_DELAY_CFG;
            s_reg.rail_slot_a            <= `RSS_RST_RAIL_SLOT_A;
            s_reg.rail_slot_b            <= `RSS_RST_RAIL_SLOT_B;
            s_reg.sequencer_reserved_cfg <= `RSS_RST_RSVD_CFG;
            s_reg.linear_reg_slot        <= `RSS_RST_LINEAR_SLOT;
            s_reg.gp_output_slot         <= `RSS_RST_GP_SLOT;
            s_reg.unlocked               <= 1'b0;
            s_reg.state                  <= RSS_OFF;
            s_reg.strobe                 <= `RSS_STROBE_FIRST;
            s_reg.cnt                    <= '0;
            s_reg.en                     <= '0;
            s_reg.busy                   <= 1'b0;
            s_reg.rdata                  <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops
    assign rail_en   = s_reg.en;
    assign reg_rdata = s_reg.rdata;
    assign seq_busy  = s_reg.busy;

endmodule : rss_sequencer

// ==== rtl/rss_map.svh ====
// Register offsets, field layout, reset values and timing figures of the rail strobe sequencer
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// ----------------------------------------------------------------------------
// Register subaddresses
// ----------------------------------------------------------------------------
`define RSS_OFS_DELAY_CFG      8'h21
`define RSS_OFS_RAIL_SLOT_A    8'h22
`define RSS_OFS_RAIL_SLOT_B    8'h23
`define RSS_OFS_RSVD_CFG       8'h24
`define RSS_OFS_LINEAR_SLOT    8'h25
`define RSS_OFS_GP_SLOT        8'h26

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define RSS_RST_DELAY_CFG      8'h00
`define RSS_RST_RAIL_SLOT_A    8'h98
`define RSS_RST_RAIL_SLOT_B    8'h75
`define RSS_RST_RSVD_CFG       8'h12
`define RSS_RST_LINEAR_SLOT    8'h63
`define RSS_RST_GP_SLOT        8'h03
`define RSS_MASK_DELAY_CFG     8'h81
`define RSS_MASK_RSVD_CFG      8'h33
`define RSS_MASK_FULL          8'hff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSS_BIT_LAST_DLY_SEL   0
`define RSS_BIT_PD_FACTOR      7

// ----------------------------------------------------------------------------
// Strobe range and slot codes
// ----------------------------------------------------------------------------
`define RSS_STROBE_FIRST       4'h1
`define RSS_STROBE_LAST        4'ha
`define RSS_STROBE_PENULT      4'h9
`define RSS_SLOT_MIN           4'h3
`define RSS_SLOT_MAX           4'ha

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RSS_CLK_KHZ            100000
`define RSS_DLY_SHORT_MS       2
`define RSS_DLY_LONG_MS        5
`define RSS_PD_FACTOR          10
`define RSS_DLY_SHORT_CYC      (`RSS_DLY_SHORT_MS * `RSS_CLK_KHZ)
`define RSS_DLY_LONG_CYC       (`RSS_DLY_LONG_MS * `RSS_CLK_KHZ)

`endif

// ==== rtl/rss_pkg.sv ====
// Types shared by the rail strobe sequencer
package rss_pkg;

    // One-hot sequencer states
    typedef enum logic [3:0] {
        RSS_OFF  = 4'b0001,
        RSS_UP   = 4'b0010,
        RSS_ON   = 4'b0100,
        RSS_DOWN = 4'b1000
    } rss_state_t;

    // Enables of every sequenced output
    typedef struct packed {
        logic gp_out_two;
        logic gp_out_one;
        logic linear_regulator;
        logic buck_three;
        logic buckboost_rail;
        logic buck_one;
        logic buck_two;
    } rss_rail_en_t;

    // Register access port from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rss_reg_req_t;

    // Whole module state
    typedef struct packed {
        logic [7:0]   delay_cfg;
        logic [7:0]   rail_slot_a;
        logic [7:0]   rail_slot_b;
        logic [7:0]   sequencer_reserved_cfg;
        logic [7:0]   linear_reg_slot;
        logic [7:0]   gp_output_slot;
        logic         unlocked;
        rss_state_t   state;
        logic [3:0]   strobe;
        logic [23:0]  cnt;
        rss_rail_en_t en;
        logic         busy;
        logic [7:0]   rdata;
    } rss_state_all_t;

endpackage : rss_pkg

// ==== verification/rss_checker.sv ====
// Port assertions of the rail strobe sequencer
`timescale 1ns/1ps
module rss_checker
    import rss_pkg::*;
#(
    parameter logic [23:0] DLY_SHORT_CYC = 24'd20,
    parameter logic [23:0] DLY_LONG_CYC  = 24'd50
) (
    input wire logic         clk,
    input wire logic         rst_n,
    input wire rss_reg_req_t reg_req,
    input wire logic         pw_unlock,
    input wire logic         pwr_up_req,
    input wire logic         pwr_dn_req,
    input wire rss_rail_en_t rail_en,
    input wire logic [7:0]   reg_rdata,
    input wire logic         seq_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Longest legal busy spell: fully stretched power-down plus slack
    localparam int BUSY_MAX = 10 * (8 * int'(DLY_SHORT_CYC) + int'(DLY_LONG_CYC)) + 16;
    logic        dir_up_reg;
    logic [31:0] busy_cnt_reg;
    // Direction of the last sequence, and busy length so a stuck busy shows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_up_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end else begin
            if (!seq_busy && (pwr_up_req || pwr_dn_req)) begin
                dir_up_reg <= pwr_up_req;
            end
            busy_cnt_reg <= seq_busy ? busy_cnt_reg + 32'd1 : 32'd0;
        end
    end
    // Sequencing and register read checks
    a_reset_clean: assert property ($rose(rst_n) |-> rail_en == '0 && !seq_busy)
        else $error("outputs not clear after reset");
    a_start_busy: assert property (!seq_busy && !dir_up_reg && $rose(pwr_up_req)
        |-> ##[1:3] seq_busy)
        else $error("power-up did not start");
    a_idle_steady: assert property (!seq_busy && !$past(seq_busy) |-> $stable(rail_en))
        else $error("enable moved while idle");
    a_up_rise_only: assert property (dir_up_reg |-> ($past(rail_en) & ~rail_en) == '0)
        else $error("enable dropped during power-up");
    a_dn_fall_only: assert property (!dir_up_reg |-> (rail_en & ~$past(rail_en)) == '0)
        else $error("enable rose during power-down");
    a_strobe_apart: assert property (seq_busy && rail_en != $past(rail_en)
        |=> $stable(rail_en) [*8])
        else $error("strobes too close together");
    a_busy_bounded: assert property (busy_cnt_reg <= BUSY_MAX)
        else $error("sequence ran too long");
    a_rsvd_zero: assert property (reg_req.rd && reg_req.addr == 8'h24
        |-> ##1 (reg_rdata & 8'hcc) == 8'h00)
        else $error("read-only bits not zero");
    c_up_done: cover property ($fell(seq_busy) && dir_up_reg);
    c_dn_done: cover property ($fell(seq_busy) && !dir_up_reg);
    c_rsvd_read: cover property (reg_req.rd && reg_req.addr == 8'h24);
endmodule : rss_checker

// ==== verification/rss_host.sv ====
// Host model: unlocks before each write unless unl is low, and reads registers back
`timescale 1ns/1ps
module rss_host
    import rss_pkg::*;
(
    input  wire logic       clk,
    output rss_reg_req_t    req,
    output logic            unlock,
    input  wire logic [7:0] rdata
);
    // Idle bus before the first access
    initial begin
        req = '0;
        unlock = 1'b0;
    end
    // Unlock then write; unl low only where a refusal is wanted
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic unl);
        @(negedge clk) unlock = unl;
        @(negedge clk) unlock = 1'b0;
        req = '{1'b1, 1'b0, a, d};
        @(negedge clk) req = '{1'b0, 1'b0, ~a, ~d}; // Released lines show no stale value
    endtask : wr
    // Read; data stands from one cycle after the request edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) req = '{1'b0, 1'b0, ~a, 8'h00};
        @(negedge clk) d = rdata;
    endtask : rd
endmodule : rss_host

// ==== verification/test_rail_strobe_sequencer_cfg.sv ====
// Self-checking bench of the rail strobe sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, s); end end
module test_rail_strobe_sequencer_cfg;
    import rss_pkg::*;
    localparam int S = 20;
    localparam int L = 50;
    logic         clk = 1'b0, rst_n = 1'b0, up = 1'b0, dn = 1'b0, unlock, busy;
    logic [7:0]   rdata, v;
    logic [6:0]   prev = '0;
    rss_reg_req_t req;
    rss_rail_en_t en, up_en;
    int           err_count = 0, compares = 0, cyc = 0, rise [7], fall [7];
    logic [7:0]   rst_tab [7] = '{8'h00, 8'h98, 8'h75, 8'h12, 8'h63, 8'h03, 8'h00};
    logic [7:0]   wa [5] = '{8'h24, 8'h25, 8'h21, 8'h26, 8'h23};
    logic [7:0]   we [5] = '{8'h33, 8'hff, 8'h81, 8'hff, 8'hff};
    rss_sequencer #(.DLY_SHORT_CYC(24'(S)), .DLY_LONG_CYC(24'(L))) rss_sequencer_inst (
        .clk(clk), .rst_n(rst_n), .reg_req(req), .pw_unlock(unlock), .pwr_up_req(up),
        .pwr_dn_req(dn), .rail_en(en), .reg_rdata(rdata), .seq_busy(busy));
    rss_host rss_host_inst (.clk(clk), .req(req), .unlock(unlock), .rdata(rdata));
    // Shortened delays keep a full stretched power-down near two thousand cycles
    always #5 clk = ~clk;
    // Edge times of every enable, taken where they have settled
    always @(negedge clk) begin
        cyc++;
        for (int i = 0; i < 7; i++) begin
            if (en[i] && !prev[i]) rise[i] = cyc;
            if (!en[i] && prev[i]) fall[i] = cyc;
        end
        prev = en;
    end
    // Cycles from strobe 3 up to the strobe a slot code names
    function automatic int upofs(input int code, input bit d9);
        return (code == 10) ? 6 * S + (d9 ? L : S) : (code - 3) * S;
    endfunction : upofs
    // Bounded wait on the busy flag
    task automatic wait_busy(input logic lvl);
        for (int n = 0; busy !== lvl; n++) begin
            if (n == 5000) report_and_stop(1);
            @(negedge clk);
        end
    endtask : wait_busy
    // One power cycle; over the runs two rails take every code
    task automatic run(input int it);
        logic [3:0] c [7];
        logic [7:0] cfg;
        int         f, e;
        for (int i = 0; i < 7; i++) c[i] = 4'($urandom);
        c[0] = 4'ha; // Last strobe carries the selectable gap
        c[4] = 4'h3;
        c[1] = 4'(2 * it + 1);
        c[6] = 4'(2 * it);
        cfg = {it[1], 6'h00, it[0]};
        f = it[1] ? 10 : 1;
        rss_host_inst.wr(8'h21, cfg, 1'b1);
        rss_host_inst.wr(8'h22, {c[0], c[1]}, 1'b1);
        rss_host_inst.wr(8'h23, {c[2], c[3]}, 1'b1);
        rss_host_inst.wr(8'h25, {4'($urandom), c[4]}, 1'b1);
        rss_host_inst.wr(8'h26, {c[6], c[5]}, 1'b1);
        up = 1'b1;
        wait_busy(1'b1);
        up = 1'b0;
        wait_busy(1'b0);
        up_en = en;
        dn = 1'b1;
        wait_busy(1'b1);
        dn = 1'b0;
        wait_busy(1'b0);
        `CHK("all off", 7'h00, en)
        for (int i = 0; i < 7; i++) begin
            `CHK("rail map", c[i] >= 4'h3 && c[i] <= 4'ha, up_en[i])
            if (c[i] >= 4'h3 && c[i] <= 4'ha) begin
                e = upofs(c[i], cfg[0]);
                `CHK("up strobe", e, rise[i] - rise[4])
                `CHK("down strobe", f * (upofs(10, cfg[0]) - e), fall[i] - fall[0])
            end
        end
    endtask : run
    // Reset map, refused write, write masks, then power cycles
    initial begin
        void'($urandom(32'hf011edbe));
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        for (int a = 0; a < 7; a++) begin
            rss_host_inst.rd(8'h21 + 8'(a), v);
            `CHK("reset value", rst_tab[a], v)
        end
        rss_host_inst.wr(8'h22, 8'h5a, 1'b0);
        rss_host_inst.rd(8'h22, v);
        `CHK("locked write", 8'h98, v)
        for (int a = 0; a < 5; a++) begin
            rss_host_inst.wr(wa[a], 8'hff, 1'b1);
            rss_host_inst.rd(wa[a], v);
            `CHK("write mask", we[a], v)
        end
        // The last accepted write re-locked, so a bare write is dropped
        rss_host_inst.wr(8'h22, 8'h5a, 1'b0);
        rss_host_inst.rd(8'h22, v);
        `CHK("relocked write", 8'h98, v)
        for (int it = 0; it < 8; it++) run(it);
        // Reset in mid power-up drops every enable and restores the slots
        up = 1'b1;
        wait_busy(1'b1);
        up = 1'b0;
        repeat (3 * S) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        `CHK("reset enables", 7'h00, en)
        rst_n = 1'b1;
        rss_host_inst.rd(8'h22, v);
        `CHK("reset slots", 8'h98, v)
        report_and_stop(0);
    end
    // Verdict and end of run
    task automatic report_and_stop(input int extra);
        err_count += extra;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
endmodule : test_rail_strobe_sequencer_cfg
bind rss_sequencer rss_checker #(.DLY_SHORT_CYC(DLY_SHORT_CYC), .DLY_LONG_CYC(DLY_LONG_CYC))
    rss_checker_inst (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .pw_unlock(pw_unlock),
    .pwr_up_req(pwr_up_req), .pwr_dn_req(pwr_dn_req), .rail_en(rail_en),
    .reg_rdata(reg_rdata), .seq_busy(seq_busy));
